// >>> inc/tcd_pkg.sv
// Purpose: Shared constants and types of the two-channel cycle-steal transfer controller.
// Assumes: 20-bit memory addresses, 16-bit memory data, word-indexed register port.
// Notes: Region bounds and register offsets are constants so the map can move in one place.
package tcd_pkg;
    localparam int AW = 20;
    localparam int DW = 16;
    localparam int CW = 16;
    localparam int RW = 32;
    localparam int NPER = 8;
    // Register indices on the plain register port.
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_SEL = 5'h01;
    localparam logic [4:0] OFS_SRC = 5'h02;
    localparam logic [4:0] OFS_DST = 5'h03;
    localparam logic [4:0] OFS_RELOAD = 5'h04;
    localparam logic [4:0] OFS_COUNT = 5'h05;
    localparam logic [4:0] OFS_FWD = 5'h06;
    localparam logic [4:0] OFS_SWREQ = 5'h07;
    localparam logic [4:0] CH_STRIDE = 5'h08;
    localparam logic [4:0] OFS_WAIT = 5'h10;
    // Control register fields.
    localparam int CB_EN = 0;
    localparam int CB_UNIT8 = 1;
    localparam int CB_REP = 2;
    localparam int CB_SFWD = 3;
    localparam int CB_DFWD = 4;
    localparam int CB_REQ = 5;
    // Request source selection codes.
    localparam logic [4:0] SEL_SW = 5'h00;
    localparam logic [4:0] SEL_EXT_FALL = 5'h01;
    localparam logic [4:0] SEL_EXT_BOTH = 5'h02;
    localparam logic [4:0] SEL_PER0 = 5'h03;
    // Address regions that cost a wait cycle.
    localparam logic [AW-1:0] SFR_LO = 20'h00000;
    localparam logic [AW-1:0] SFR_HI = 20'h003ff;
    localparam logic [AW-1:0] OSD_LO = 20'h00600;
    localparam logic [AW-1:0] OSD_HI = 20'h007ff;
    // Cycle coefficients and bus cycle counts.
    localparam logic [1:0] COEF_NOWAIT = 2'h1;
    localparam logic [1:0] COEF_WAIT = 2'h2;
    localparam logic [1:0] COEF_SFR = 2'h2;
    localparam logic [1:0] N_SINGLE = 2'h1;
    localparam logic [1:0] N_SPLIT = 2'h2;
    localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [AW-1:0] STEP8 = 20'h00001;
    localparam logic [AW-1:0] STEP16 = 20'h00002;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} tcd_state_t;
endpackage : tcd_pkg

// >>> rtl/tcd_dma.sv
// Purpose: Two-channel cycle-steal transfer controller sharing the on-chip bus with the CPU.
// Assumes: Peripheral request pulses are on core_clk; external request pins are asynchronous.
// Notes: Each request moves one unit, then the CPU gets one bus access before the next unit.
// Overview of operation
// - Unit cost is reads times j plus writes times k.
// - Odd 16-bit source takes two reads; odd destination two writes.
// - Coefficient 1 plain memory, 2 waited or SFR/OSD.
// - Any even/odd source and destination mix accepted.
// - Enable write loads forward pointer at first transfer.
// - First transfer also loads counter from reload.
// - Rewriting enable restarts channel from initial state.
// - Request bit sets regardless of enable bit.
// - Request bit clears just before transfer starts.
// - Software writes 0 clear request; 1 ignored.
// - Source is peripheral, software trigger or pin.
// - Peripheral request sets with its interrupt flag.
// - Pin request follows the selected pin edge.
// - Simultaneous requests set both; channel zero first.
// - CPU gets one access between channel transfers.
// - Single mode underflow clears enable bit.
// - Repeat mode underflow reloads counter, stays active.
// - Forward increment never on both source and destination.
`timescale 1ns/100ps
module tcd_dma (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [4:0] reg_addr,
    input wire logic [tcd_pkg::RW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tcd_pkg::RW-1:0] reg_rdata,
    input wire logic [tcd_pkg::NPER-1:0] periph_req,
    input wire logic [1:0] external_request_pin,
    input wire logic cpu_access_done,
    output logic mbus_own,
    output logic mbus_rd,
    output logic mbus_wr,
    output logic mbus_byte,
    output logic [tcd_pkg::AW-1:0] mbus_addr,
    output logic [tcd_pkg::DW-1:0] mbus_wdata,
    input wire logic [tcd_pkg::DW-1:0] mbus_rdata
);
    import tcd_pkg::*;

    typedef struct packed {
        tcd_state_t st;
        logic [1:0] en;
        logic [1:0] unit8;
        logic [1:0] rep;
        logic [1:0] sfwd;
        logic [1:0] dfwd;
        logic [1:0] req;
        logic [1:0] fresh;
        logic [1:0][4:0] sel;
        logic [1:0][AW-1:0] src;
        logic [1:0][AW-1:0] dst;
        logic [1:0][AW-1:0] fwd;
        logic [1:0][CW-1:0] reload;
        logic [1:0][CW-1:0] count;
        logic wait_en;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_d;
        logic ch;
        logic phase;
        logic [1:0] tick;
        logic [AW-1:0] raddr;
        logic [AW-1:0] waddr;
        logic [DW-1:0] data;
        logic own;
        logic mrd;
        logic mwr;
        logic mbyte;
        logic [AW-1:0] maddr;
        logic [DW-1:0] mwdata;
        logic [RW-1:0] rdata;
    } tcd_state_s_t;

    tcd_state_s_t s;
    tcd_state_s_t next_s;
    logic [1:0] ev;
    logic last;
    logic fin;

    // Cost of one bus cycle at an address.
    function automatic logic [1:0] coef(input logic [AW-1:0] a, input logic w);
        if ((a >= SFR_LO && a <= SFR_HI) || (a >= OSD_LO && a <= OSD_HI)) begin
            coef = COEF_SFR;
        end else begin
            coef = w ? COEF_WAIT : COEF_NOWAIT;
        end
    endfunction : coef

    // Number of bus cycles for one side of a unit.
    function automatic logic [1:0] ncyc(input logic u8, input logic a0);
        ncyc = (!u8 && a0) ? N_SPLIT : N_SINGLE;
    endfunction : ncyc

    function automatic logic [4:0] ch_ofs(input logic c, input logic [4:0] o);
        ch_ofs = c ? 5'(CH_STRIDE + o) : o;
    endfunction : ch_ofs

    always_comb begin
        logic c;
        logic [DW-1:0] d;
        logic [AW-1:0] fp;
        c = 1'b0;
        d = '0;
        fp = '0;
        next_s = s;
        next_s.rdata = '0;
        // Two flops tame the asynchronous pins; edges are taken only after them.
        next_s.pin_s1 = external_request_pin;
        next_s.pin_s2 = s.pin_s1;
        next_s.pin_d = s.pin_s2;
        last = s.tick == 2'(coef(s.maddr, s.wait_en) - 2'h1);
        fin = 1'b0;
        for (int i = 0; i < 2; i++) begin
            case (s.sel[i])
                SEL_SW: ev[i] = reg_wr && reg_addr == ch_ofs(1'(i), OFS_SWREQ) && reg_wdata[0];
                SEL_EXT_FALL: ev[i] = s.pin_d[i] && !s.pin_s2[i];
                SEL_EXT_BOTH: ev[i] = s.pin_d[i] != s.pin_s2[i];
                default: begin
                    ev[i] = (s.sel[i] >= SEL_PER0) && (s.sel[i] < 5'(SEL_PER0 + NPER))
                        && periph_req[3'(s.sel[i] - SEL_PER0)];
                end
            endcase
            if (reg_rd) begin
                if (reg_addr == ch_ofs(1'(i), OFS_CTRL)) begin
                    next_s.rdata = RW'({s.req[i], s.dfwd[i], s.sfwd[i], s.rep[i], s.unit8[i], s.en[i]});
                end
                if (reg_addr == ch_ofs(1'(i), OFS_SEL)) next_s.rdata = RW'(s.sel[i]);
                if (reg_addr == ch_ofs(1'(i), OFS_SRC)) next_s.rdata = RW'(s.src[i]);
                if (reg_addr == ch_ofs(1'(i), OFS_DST)) next_s.rdata = RW'(s.dst[i]);
                if (reg_addr == ch_ofs(1'(i), OFS_RELOAD)) next_s.rdata = RW'(s.reload[i]);
                if (reg_addr == ch_ofs(1'(i), OFS_COUNT)) next_s.rdata = RW'(s.count[i]);
                if (reg_addr == ch_ofs(1'(i), OFS_FWD)) next_s.rdata = RW'(s.fwd[i]);
            end
            if (reg_wr) begin
                if (reg_addr == ch_ofs(1'(i), OFS_CTRL)) begin
                    next_s.en[i] = reg_wdata[CB_EN];
                    next_s.fresh[i] = reg_wdata[CB_EN];
                    next_s.unit8[i] = reg_wdata[CB_UNIT8];
                    next_s.rep[i] = reg_wdata[CB_REP];
                    next_s.sfwd[i] = reg_wdata[CB_SFWD];
                    next_s.dfwd[i] = reg_wdata[CB_DFWD] && !reg_wdata[CB_SFWD];
                    if (!reg_wdata[CB_REQ]) next_s.req[i] = 1'b0;
                end
                if (reg_addr == ch_ofs(1'(i), OFS_SEL)) next_s.sel[i] = reg_wdata[4:0];
                if (reg_addr == ch_ofs(1'(i), OFS_SRC)) next_s.src[i] = reg_wdata[AW-1:0];
                if (reg_addr == ch_ofs(1'(i), OFS_DST)) next_s.dst[i] = reg_wdata[AW-1:0];
                if (reg_addr == ch_ofs(1'(i), OFS_RELOAD)) next_s.reload[i] = reg_wdata[CW-1:0];
            end
        end
        if (reg_rd && reg_addr == OFS_WAIT) next_s.rdata = RW'(s.wait_en);
        if (reg_wr && reg_addr == OFS_WAIT) next_s.wait_en = reg_wdata[0];
        case (s.st)
            ST_IDLE: begin
                if ((s.req[0] && s.en[0]) || (s.req[1] && s.en[1])) begin
                    c = !(s.req[0] && s.en[0]);
                    next_s.ch = c;
                    next_s.req[c] = 1'b0;
                    fp = s.fwd[c];
                    if (s.fresh[c]) begin
                        fp = s.sfwd[c] ? s.src[c] : s.dst[c];
                        next_s.fwd[c] = fp;
                        next_s.count[c] = s.reload[c];
                        // An enable rewrite in this same cycle asks for another reload at the next start.
                        if (!(reg_wr && reg_addr == ch_ofs(c, OFS_CTRL))) next_s.fresh[c] = 1'b0;
                    end
                    next_s.raddr = s.sfwd[c] ? fp : s.src[c];
                    next_s.waddr = s.dfwd[c] ? fp : s.dst[c];
                    next_s.st = ST_READ;
                    next_s.own = 1'b1;
                    next_s.mrd = 1'b1;
                    next_s.maddr = next_s.raddr;
                    next_s.mbyte = s.unit8[c] || next_s.raddr[0];
                    next_s.phase = 1'b0;
                    next_s.tick = 2'h0;
                end
            end
            ST_READ: begin
                next_s.tick = 2'(s.tick + 2'h1);
                if (last) begin
                    next_s.tick = 2'h0;
                    if (ncyc(s.unit8[s.ch], s.raddr[0]) == N_SPLIT && !s.phase) begin
                        next_s.data[7:0] = mbus_rdata[7:0];
                        next_s.phase = 1'b1;
                        next_s.maddr = 20'(s.raddr + STEP8);
                    end else begin
                        if (s.phase) d = {mbus_rdata[7:0], s.data[7:0]};
                        else if (s.unit8[s.ch]) d = {8'h00, mbus_rdata[7:0]};
                        else d = mbus_rdata;
                        next_s.data = d;
                        next_s.st = ST_WRITE;
                        next_s.phase = 1'b0;
                        next_s.mrd = 1'b0;
                        next_s.mwr = 1'b1;
                        next_s.maddr = s.waddr;
                        next_s.mbyte = s.unit8[s.ch] || s.waddr[0];
                        next_s.mwdata = next_s.mbyte ? {8'h00, d[7:0]} : d;
                    end
                end
            end
            ST_WRITE: begin
                next_s.tick = 2'(s.tick + 2'h1);
                if (last) begin
                    next_s.tick = 2'h0;
                    if (ncyc(s.unit8[s.ch], s.waddr[0]) == N_SPLIT && !s.phase) begin
                        next_s.phase = 1'b1;
                        next_s.maddr = 20'(s.waddr + STEP8);
                        next_s.mwdata = {8'h00, s.data[15:8]};
                    end else begin
                        fin = 1'b1;
                        next_s.st = ST_GAP;
                        next_s.own = 1'b0;
                        next_s.mwr = 1'b0;
                        // A restart written during the last write cycle wins over the count update.
                        if (!next_s.fresh[s.ch]) begin
                            next_s.fwd[s.ch] = 20'(s.fwd[s.ch] + (s.unit8[s.ch] ? STEP8 : STEP16));
                            next_s.count[s.ch] = 16'(s.count[s.ch] - 16'h0001);
                            if (s.count[s.ch] == CNT_ZERO) begin
                                if (s.rep[s.ch]) next_s.count[s.ch] = s.reload[s.ch];
                                else next_s.en[s.ch] = 1'b0;
                            end
                        end
                    end
                end
            end
            // Stay off the bus until the CPU has made its one access.
            ST_GAP: begin
                if (cpu_access_done) next_s.st = ST_IDLE;
            end
            default: next_s.st = ST_IDLE;
        endcase
        // A new request wins over any clear in the same cycle.
        next_s.req = next_s.req | ev;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign mbus_own = s.own;
    assign mbus_rd = s.mrd;
    assign mbus_wr = s.mwr;
    assign mbus_byte = s.mbyte;
    assign mbus_addr = s.maddr;
    assign mbus_wdata = s.mwdata;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_one_read;
        mbus_rd ##1 !mbus_rd;
    endsequence
    sequence s_two_read;
        mbus_rd [*2] ##1 !mbus_rd;
    endsequence

    AST_COEF_PLAIN: assert property ($rose(mbus_rd) && !mbus_byte && coef(mbus_addr, s.wait_en) == COEF_NOWAIT
        |-> s_one_read) else $error("plain read not one cycle");
    AST_COEF_WAIT: assert property ($rose(mbus_rd) && !mbus_byte && coef(mbus_addr, s.wait_en) == COEF_WAIT
        |-> s_two_read ##0 mbus_wr) else $error("waited read not two cycles");
    AST_SPLIT_READ: assert property ($rose(mbus_rd) && !s.unit8[s.ch] && mbus_addr[0]
        |-> ##[1:2] (mbus_rd && mbus_addr == 20'($past(s.raddr) + STEP8))) else $error("odd word not split");
    AST_REQ_SET: assert property (ev[0] |=> s.req[0]) else $error("request lost");
    AST_REQ_CLR0: assert property ($rose(mbus_own) && !s.ch && !$past(ev[0]) |-> !s.req[0])
        else $error("request not cleared at start");
    AST_REQ_CLR1: assert property ($rose(mbus_own) && s.ch && !$past(ev[1]) |-> !s.req[1])
        else $error("request not cleared at start");
    AST_PRIO: assert property (s.st == ST_IDLE && (s.req & s.en) == 2'b11 |=> mbus_own && !s.ch)
        else $error("channel zero not first");
    AST_GAP: assert property ($fell(mbus_own) |-> s.st == ST_GAP ##1 (!mbus_own || $past(cpu_access_done)))
        else $error("no CPU access between units");
    AST_RELOAD: assert property ($rose(mbus_own) && !s.ch && $past(s.fresh[0])
        |-> s.count[0] == $past(s.reload[0])) else $error("counter not reloaded");
    AST_SINGLE_END: assert property (fin && !s.ch && s.count[0] == CNT_ZERO && !s.rep[0] && !s.fresh[0]
        && !reg_wr |=> !s.en[0]) else $error("single mode stays enabled");
    AST_REPEAT_END: assert property (fin && !s.ch && s.count[0] == CNT_ZERO && s.rep[0] && !s.fresh[0]
        && !reg_wr |=> s.en[0] && s.count[0] == $past(s.reload[0])) else $error("repeat not reloaded");
    AST_FWD_EXCL: assert property (!(s.sfwd[1] && s.dfwd[1]) && !(s.sfwd[0] && s.dfwd[0]))
        else $error("both sides forward");
    AST_UNIT_END: assert property ($fell(mbus_own) |-> $past(mbus_wr) && !mbus_rd)
        else $error("bus returned mid unit");

    // Write side of a unit has the same cycle lengths as the read side.
    sequence s_one_write;
        mbus_wr ##1 !mbus_wr;
    endsequence
    sequence s_two_write;
        mbus_wr [*2] ##1 !mbus_wr;
    endsequence

    AST_WCOEF_PLAIN: assert property ($rose(mbus_wr) && !mbus_byte && coef(mbus_addr, s.wait_en) == COEF_NOWAIT
        |-> s_one_write) else $error("plain write not one cycle");
    AST_WCOEF_WAIT: assert property ($rose(mbus_wr) && !mbus_byte && coef(mbus_addr, s.wait_en) == COEF_WAIT
        |-> s_two_write ##0 !mbus_own) else $error("waited write not two cycles");
    AST_SPLIT_WRITE: assert property ($rose(mbus_wr) && !s.unit8[s.ch] && mbus_addr[0]
        |-> ##[1:2] (mbus_wr && mbus_addr == 20'(s.waddr + STEP8))) else $error("odd word write not split");
    AST_BUS_ONE_WAY: assert property (!(mbus_rd && mbus_wr) && (!(mbus_rd || mbus_wr) || mbus_own))
        else $error("bus strobe outside ownership");

    // Request bit: set by its source, cleared only by software or a start.
    AST_REQ_SET1: assert property (ev[1] |=> s.req[1]) else $error("request lost");
    AST_SW_ONE: assert property (reg_wr && reg_addr == ch_ofs(1'b1, OFS_CTRL) && reg_wdata[CB_REQ] && !s.en[1]
        |=> s.req[1] == $past(s.req[1] || ev[1])) else $error("request written to one");
    AST_SW_CLEAR: assert property (reg_wr && reg_addr == ch_ofs(1'b1, OFS_CTRL) && !reg_wdata[CB_REQ] && !ev[1]
        |=> !s.req[1]) else $error("request not cleared by software");
    AST_PER_REQ: assert property (s.sel[0] == 5'(SEL_PER0 + 5'h02) && periph_req[2] |=> s.req[0])
        else $error("peripheral request lost");
    AST_EXT_FALL0: assert property (s.sel[0] == SEL_EXT_FALL && $fell(s.pin_s2[0]) |=> s.req[0])
        else $error("pin falling edge lost");
    AST_NO_EXT_RISE: assert property (s.sel[1] == SEL_EXT_FALL && !s.req[1] && !$fell(s.pin_s2[1])
        |=> !s.req[1]) else $error("request without falling edge");

    // Start of a unit: reloads and pointer.
    AST_START_ONE: assert property ($rose(mbus_own) |-> mbus_rd && $past(s.st) == ST_IDLE)
        else $error("unit does not open with a read");
    AST_FWD_LOAD: assert property ($rose(mbus_own) && !s.ch && $past(s.fresh[0])
        |-> s.fwd[0] == ($past(s.sfwd[0]) ? $past(s.src[0]) : $past(s.dst[0])))
        else $error("forward pointer not loaded");
    AST_RELOAD1: assert property ($rose(mbus_own) && s.ch && $past(s.fresh[1])
        |-> s.count[1] == $past(s.reload[1])) else $error("counter not reloaded");

    // End of a unit: underflow handling and the CPU gap.
    AST_SINGLE_END1: assert property (fin && s.ch && s.count[1] == CNT_ZERO && !s.rep[1] && !s.fresh[1]
        && !reg_wr |=> !s.en[1]) else $error("single mode stays enabled");
    AST_REPEAT_END1: assert property (fin && s.ch && s.count[1] == CNT_ZERO && s.rep[1] && !s.fresh[1]
        && !reg_wr |=> s.en[1] && s.count[1] == $past(s.reload[1])) else $error("repeat not reloaded");
    AST_GAP_HOLD: assert property (s.st == ST_GAP && !cpu_access_done |=> s.st == ST_GAP && !mbus_own)
        else $error("bus taken before CPU access");
endmodule : tcd_dma

// >>> dv/tcd_cpu_mem.sv
// Purpose: CPU core and byte-wide memory on the far side of the shared bus.
// Assumes: Controller bus outputs are registered on core_clk.
// Notes: Idle read data toggles every cycle so stale values are never taken as data.
`timescale 1ns/100ps
module tcd_cpu_mem (
    input wire logic core_clk,
    input wire logic mbus_own,
    input wire logic mbus_rd,
    input wire logic mbus_wr,
    input wire logic mbus_byte,
    input wire logic [tcd_pkg::AW-1:0] mbus_addr,
    input wire logic [tcd_pkg::DW-1:0] mbus_wdata,
    input wire logic [3:0] cpu_delay,
    output logic [tcd_pkg::DW-1:0] mbus_rdata,
    output logic cpu_access_done
);
    import tcd_pkg::*;
    logic [7:0] mem [int];
    initial begin
        mbus_rdata = 16'h0000;
        cpu_access_done = 1'b0;
    end
    function automatic logic [7:0] rb(input int a);
        return mem.exists(a) ? mem[a] : 8'h3c;
    endfunction : rb
    always @(negedge core_clk) begin
        if (mbus_rd) begin
            mbus_rdata <= {rb(int'(mbus_addr) + 1), rb(int'(mbus_addr))};
        end else begin
            mbus_rdata <= ~mbus_rdata;
        end
    end
    always @(posedge core_clk) begin
        if (mbus_wr) begin
            mem[int'(mbus_addr)] = mbus_wdata[7:0];
            if (!mbus_byte) begin
                mem[int'(mbus_addr) + 1] = mbus_wdata[15:8];
            end
        end
    end
    // The CPU makes one bus access, at its own pace, each time the controller lets go.
    always @(negedge mbus_own) begin
        repeat (cpu_delay + 1) @(posedge core_clk);
        cpu_access_done <= 1'b1;
        @(posedge core_clk);
        cpu_access_done <= 1'b0;
    end
endmodule : tcd_cpu_mem

// >>> dv/tb_top.sv
// Purpose: Self-checking bench of the two-channel transfer controller.
// Assumes: Registers reached through the strobe port; CPU and memory are modelled.
// Notes: Costs, pointers and counts are worked out here from the unit rules.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    import tcd_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [RW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [NPER-1:0] periph_req = '0;
    logic [1:0] pins = 2'h3;
    logic [3:0] cpu_delay = 4'h0;
    logic [RW-1:0] reg_rdata, rv;
    logic cpu_access_done, mbus_own, mbus_rd, mbus_wr, mbus_byte;
    logic [AW-1:0] mbus_addr;
    logic [DW-1:0] mbus_wdata, mbus_rdata;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int cpu_seen = 0;
    always #4 core_clk = ~core_clk;
    tcd_dma dut_u (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
        .external_request_pin(pins), .cpu_access_done(cpu_access_done), .mbus_own(mbus_own),
        .mbus_rd(mbus_rd), .mbus_wr(mbus_wr), .mbus_byte(mbus_byte), .mbus_addr(mbus_addr),
        .mbus_wdata(mbus_wdata), .mbus_rdata(mbus_rdata));
    tcd_cpu_mem mem_u (.core_clk(core_clk), .mbus_own(mbus_own), .mbus_rd(mbus_rd), .mbus_wr(mbus_wr),
        .mbus_byte(mbus_byte), .mbus_addr(mbus_addr), .mbus_wdata(mbus_wdata), .cpu_delay(cpu_delay),
        .mbus_rdata(mbus_rdata), .cpu_access_done(cpu_access_done));
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge core_clk) begin
        cycles++;
        if (cpu_access_done === 1'b1) begin
            cpu_seen++;
        end
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wr(input int a, input int d);
        @(posedge core_clk);
        reg_addr <= a[4:0];
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input int a);
        @(posedge core_clk);
        reg_addr <= a[4:0];
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    function automatic int coef(input int a, input bit wt);
        if (a <= SFR_HI || (a >= OSD_LO && a <= OSD_HI)) return 2;
        return wt ? 2 : 1;
    endfunction : coef
    // Waits a bounded time for the controller to take the bus, then counts its cycles.
    task automatic grab(output int cyc, output logic [AW-1:0] a0);
        int n;
        n = 0;
        while (mbus_own !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            #1 n++;
        end
        a0 = mbus_addr;
        cyc = 0;
        while (mbus_own === 1'b1 && cyc < 60) begin
            cyc++;
            @(posedge core_clk);
            #1;
        end
    endtask : grab
    task automatic unit(input int ch, input bit u8, input int s, input int d, input bit wt);
        int b, cyc, cost;
        logic [AW-1:0] a0;
        b = ch * 8;
        cost = coef(s, wt) + coef(d, wt);
        if (!u8 && s[0]) cost += coef(s + 1, wt);
        if (!u8 && d[0]) cost += coef(d + 1, wt);
        mem_u.mem[s] = 8'($urandom);
        mem_u.mem[s + 1] = 8'($urandom);
        wr(OFS_WAIT, wt);
        wr(b + OFS_SRC, s);
        wr(b + OFS_DST, d);
        wr(b + OFS_RELOAD, 3);
        wr(b + OFS_CTRL, 9 + 2 * u8);
        wr(b + OFS_SWREQ, 1);
        grab(cyc, a0);
        `CHK("unit cost", cost, cyc)
        `CHK("first address", s[AW-1:0], a0)
        `CHK("low byte", mem_u.mem[s], mem_u.mem[d])
        if (!u8) `CHK("high byte", mem_u.mem[s + 1], mem_u.mem[d + 1])
        rd(b + OFS_CTRL);
        `CHK("request after start", 1'b0, rv[CB_REQ])
        rd(b + OFS_COUNT);
        `CHK("count", 32'h2, rv)
        rd(b + OFS_FWD);
        `CHK("pointer", s + (u8 ? 1 : 2), rv)
    endtask : unit
    initial begin
        int cyc, n;
        int base [3];
        logic [AW-1:0] a0;
        base = '{32'h100, 32'h640, 32'h2000};
        void'($urandom(32'h47fc2f91));
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        rd(5'h1f);
        `CHK("unmapped read", 32'h0, rv)
        wr(OFS_CTRL, 32'h18);
        rd(OFS_CTRL);
        `CHK("both forward", 32'h08, rv & 32'h18)
        wr(CH_STRIDE + OFS_CTRL, 0);
        wr(CH_STRIDE + OFS_SWREQ, 1);
        rd(CH_STRIDE + OFS_CTRL);
        `CHK("request while off", 32'h20, rv)
        wr(CH_STRIDE + OFS_CTRL, 32'h20);
        rd(CH_STRIDE + OFS_CTRL);
        `CHK("request write one", 32'h20, rv)
        wr(CH_STRIDE + OFS_CTRL, 0);
        rd(CH_STRIDE + OFS_CTRL);
        `CHK("request write zero", 32'h0, rv)
        wr(OFS_SEL, SEL_PER0 + 2);
        wr(OFS_CTRL, 0);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            periph_req <= i ? 8'h04 : 8'hfb;
            @(posedge core_clk);
            periph_req <= 8'h00;
            rd(OFS_CTRL);
            `CHK("peripheral request", i ? 32'h20 : 32'h0, rv)
        end
        wr(OFS_SEL, SEL_SW);
        wr(OFS_CTRL, 0);
        for (int i = 0; i < 16; i++) begin
            cpu_delay <= $urandom % 4;
            n = $urandom % 3;
            unit($urandom % 2, $urandom % 2, base[n] + $urandom % 64, base[$urandom % 3] + 128 + $urandom % 64,
                $urandom % 2);
        end
        for (int m = 0; m < 4; m++) begin
            n = m / 2 * 8;
            wr(n + OFS_RELOAD, 0);
            wr(n + OFS_CTRL, m[0] ? 32'h0d : 32'h09);
            wr(n + OFS_SWREQ, 1);
            grab(cyc, a0);
            rd(n + OFS_CTRL);
            `CHK("enable after underflow", m[0], rv[CB_EN])
            rd(n + OFS_COUNT);
            `CHK("count after underflow", m[0] ? 32'h0 : 32'hffff, rv)
        end
        cpu_delay <= 4'h2;
        for (int c = 0; c < 2; c++) begin
            wr(c * 8 + OFS_SEL, SEL_EXT_FALL);
            wr(c * 8 + OFS_SRC, 32'h3000 + c * 16);
            wr(c * 8 + OFS_RELOAD, 5);
            wr(c * 8 + OFS_CTRL, 9);
        end
        @(posedge core_clk);
        pins <= 2'h0;
        grab(cyc, a0);
        n = cpu_seen;
        `CHK("first channel", 20'h03000, a0)
        grab(cyc, a0);
        `CHK("second channel", 20'h03010, a0)
        `CHK("cpu accesses between", 1, cpu_seen - n)
        wr(OFS_SEL, SEL_EXT_BOTH);
        wr(OFS_CTRL, 9);
        @(posedge core_clk);
        pins <= 2'h3;
        grab(cyc, a0);
        `CHK("rising edge both", 20'h03000, a0)
        grab(cyc, a0);
        `CHK("rising edge falling only", 0, cyc)
        wrap_up();
    end
endmodule : tb_top
